// >>> logic/idt_pkg.sv
// shared constants and types of the interval delay timer
// Overview of operation
// R1: configuration 0 output low on count load
// R2: configuration 0 counts to zero, output high
// R3: configuration 0 low gate holds count
// R4: configuration 1 gate rise starts cycle, output low
// R5: configuration 1 retriggers from loaded count
// R6: configuration 1 output high at zero
// R7: configuration 4 output high, one-clock low strobe
// R8: configuration 5 gate-started one-clock low strobe
// R9: configuration 5 gate rise restarts cycle
// R10: counter 2 runs from 1 MHz tick
// R11: counter 2 gate-high width measurement
// R12: host gates known interval, monitors gate
// R13: counter 2 square wave clocks other counters
// R14: armed counter 2 output raises interrupt
// R15: pair mode loads and reads low then high
// R16: latch command freezes count for reading
// R17: decrement by one per clock tick
// R18: load completes after final byte written
package idt_pkg;
   // clock rates
   localparam int unsigned IDT_CLK_HZ    = 100_000_000;
   localparam int unsigned IDT_TICK_HZ   = 1_000_000;
   localparam int unsigned IDT_TICK_DIV  = IDT_CLK_HZ / IDT_TICK_HZ;
   localparam int          IDT_NCNT      = 3;
   localparam int          IDT_NIRQ      = 4;
   // register byte addresses
   localparam logic [7:0]  IDT_ADR_CNT0  = 8'h00;
   localparam logic [7:0]  IDT_ADR_CNT1  = 8'h04;
   localparam logic [7:0]  IDT_ADR_CNT2  = 8'h08;
   localparam logic [7:0]  IDT_ADR_CTRL  = 8'h0C;
   localparam logic [7:0]  IDT_ADR_BRD   = 8'h10;
   localparam logic [7:0]  IDT_ADR_ISTAT = 8'h14;
   localparam logic [7:0]  IDT_ADR_IMASK = 8'h18;
   localparam logic [7:0]  IDT_ADR_STAT  = 8'h1C;
   // control byte fields
   localparam int          IDT_CW_SC     = 6;
   localparam int          IDT_CW_RL     = 4;
   localparam int          IDT_CW_M      = 1;
   localparam logic [1:0]  IDT_SC_RDBK   = 2'b11;
   localparam logic [1:0]  IDT_RL_LATCH  = 2'b00;
   localparam logic [1:0]  IDT_RL_LO     = 2'b01;
   localparam logic [1:0]  IDT_RL_HI     = 2'b10;
   localparam logic [1:0]  IDT_RL_PAIR   = 2'b11;
   // board control, interrupt and status fields
   localparam int          IDT_BRD_ARM   = 0;
   localparam int          IDT_BRD_CASC  = 1;
   localparam int          IDT_IRQ_TMR   = 0;
   localparam int          IDT_IRQ_OUT   = 1;
   localparam int          IDT_STAT_OUT  = 0;
   localparam int          IDT_STAT_GATE = 4;
   // count values
   localparam logic [15:0] IDT_ONE       = 16'h0001;
   localparam logic [15:0] IDT_ZERO      = 16'h0000;
   localparam logic [7:0]  IDT_BYTE0     = 8'h00;

   typedef enum logic [2:0] {
      IDT_M_TCOUNT   = 3'b000,
      IDT_M_ONESHOT  = 3'b001,
      IDT_M_RATE     = 3'b010,
      IDT_M_SQUARE   = 3'b011,
      IDT_M_SWSTROBE = 3'b100,
      IDT_M_HWSTROBE = 3'b101
   } idt_mode_t;

   typedef struct packed {
      idt_mode_t   mode;
      logic [1:0]  rl;
      logic [15:0] count;
      logic [15:0] reload;
      logic [15:0] hold;
      logic        held;
      logic        wr_hi;
      logic        rd_hi;
      logic [7:0]  lo_tmp;
      logic        outv;
      logic        ldd;
      logic        pend;
      logic        trig;
      logic        run;
   } idt_cnt_t;
endpackage

// >>> logic/idt_tick_gen.sv
// divider making the one-cycle count tick for the internal counter
`timescale 1ns/10ps
`default_nettype none
module idt_tick_gen
   import idt_pkg::*;
#(
   parameter int unsigned DIV = IDT_TICK_DIV
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // tick
   output logic      tick_o
);
   localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] div_reg;
   logic [W-1:0] div_next;
   logic         tick_reg;
   logic         tick_next;

   always_comb begin
      tick_next = (div_reg == LAST);
      div_next  = tick_next ? '0 : div_reg + W'(1);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         div_reg  <= div_next;
         tick_reg <= tick_next;
      end
   end

   assign tick_o = tick_reg;
endmodule
`default_nettype wire

// >>> logic/idt_rise_det.sv
// rising edge detectors for clock, gate and cascade levels
`timescale 1ns/10ps
`default_nettype none
module idt_rise_det #(
   parameter int W = 6
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // levels and their rises
   input  wire logic [W-1:0] sig_i,
   output logic      [W-1:0] rise_o
);
   logic [W-1:0] prev_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= sig_i;
      end
   end

   assign rise_o = sig_i & ~prev_reg;
endmodule
`default_nettype wire

// >>> logic/idt_timer.sv
// three-counter down-counting interval timer with wishbone registers
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module idt_timer
   import idt_pkg::*;
#(
   parameter int unsigned TICK_DIV = IDT_TICK_DIV
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // counter pins
   input  wire logic [1:0]  cnt_clk_i,
   input  wire logic [2:0]  gate_i,
   output logic      [2:0]  cnt_out_o,
   // interrupt
   output logic             irq_o
);
   typedef struct packed {
      idt_cnt_t [IDT_NCNT-1:0] cnt;
      logic                    ack;
      logic [31:0]             dat;
      logic                    arm;
      logic [1:0]              casc;
      logic [IDT_NIRQ-1:0]     istat;
      logic [IDT_NIRQ-1:0]     imask;
      logic                    irq;
   } idt_state_t;

   idt_state_t s_reg;
   idt_state_t s_next;

   logic       us_tick;
   logic [5:0] rise;
   logic [2:0] tick;

   // positions in the rise vector, and the no-counter code of cnt_sel
   localparam int         RISE_GATE = 2;
   localparam int         RISE_CASC = 5;
   localparam logic [1:0] NO_CNT    = 2'h3;

   idt_tick_gen #(
      .DIV    (TICK_DIV)
   ) u_tick (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_o (us_tick)
   );

   // counter 2 output goes through the detector so cascading counts its rises only
   idt_rise_det #(
      .W      (6)
   ) u_rise (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .sig_i  ({s_reg.cnt[2].outv, gate_i, cnt_clk_i}),
      .rise_o (rise)
   );

   // counter 2 always runs from the 1 us tick; 0 and 1 may take its output instead
   always_comb begin
      tick[0] = s_reg.casc[0] ? rise[RISE_CASC] : rise[0]; // [R13]
      tick[1] = s_reg.casc[1] ? rise[RISE_CASC] : rise[1]; // [R13]
      tick[2] = us_tick;                           // [R10] [R11]
   end

   // codes 110 and 111 are aliases of the rate and square configurations
   function automatic idt_mode_t mode_dec(input logic [2:0] m);
      idt_mode_t r;
      case (m)
         3'b000:  r = IDT_M_TCOUNT;
         3'b001:  r = IDT_M_ONESHOT;
         3'b100:  r = IDT_M_SWSTROBE;
         3'b101:  r = IDT_M_HWSTROBE;
         3'b011,
         3'b111:  r = IDT_M_SQUARE;
         default: r = IDT_M_RATE;
      endcase
      return r;
   endfunction

   // one count tick of a counter, gate rise remembered until the next tick
   function automatic idt_cnt_t step(input idt_cnt_t c, input logic tk,
                                     input logic gt, input logic gr);
      idt_cnt_t    r;
      logic [15:0] dec;
      r   = c;
      dec = c.count - IDT_ONE;
      if (tk) begin
         case (c.mode)
            IDT_M_TCOUNT,
            IDT_M_SWSTROBE: begin
               r.trig = 1'b0;
               if (c.mode == IDT_M_SWSTROBE && !c.outv) begin
                  r.outv = 1'b1; // [R7]
               end
               if (c.pend) begin
                  r.count = c.reload; // [R18]
                  r.pend  = 1'b0;
                  r.run   = 1'b1;
               end else if (gt) begin // [R3]
                  r.count = dec; // [R17]
                  if (c.run && dec == IDT_ZERO) begin
                     r.run  = 1'b0;
                     r.outv = (c.mode == IDT_M_TCOUNT); // [R2] [R7]
                  end
               end
            end
            IDT_M_ONESHOT,
            IDT_M_HWSTROBE: begin
               if (c.mode == IDT_M_HWSTROBE && !c.outv) begin
                  r.outv = 1'b1; // [R8]
               end
               if (c.trig && c.ldd) begin
                  r.count = c.reload; // [R4] [R5] [R9]
                  r.trig  = 1'b0;
                  r.run   = 1'b1;
                  if (c.mode == IDT_M_ONESHOT) begin
                     r.outv = 1'b0; // [R4]
                  end
               end else begin
                  r.trig = 1'b0;
                  if (c.run) begin // gate level ignored here [R5]
                     r.count = dec; // [R17]
                     if (dec == IDT_ZERO) begin
                        r.run  = 1'b0;
                        r.outv = (c.mode == IDT_M_ONESHOT); // [R6] [R8]
                     end
                  end
               end
            end
            default: begin
               if ((c.pend || c.trig) && c.ldd) begin
                  r.count = c.reload;
                  r.pend  = 1'b0;
                  r.trig  = 1'b0;
                  r.outv  = 1'b1;
               end else if (gt && c.ldd) begin
                  if (c.count <= IDT_ONE) begin
                     r.count = c.reload;
                     r.outv  = 1'b1;
                  end else begin
                     r.count = dec; // [R17]
                     // odd divisors leave the high half one tick longer
                     r.outv  = (c.mode == IDT_M_SQUARE) ? (dec > (c.reload >> 1))
                                                        : (dec != IDT_ONE); // [R13]
                  end
               end
            end
         endcase
      end
      // a gate rise lands after the tick so it is never lost
      if (gr) begin
         r.trig = 1'b1;
      end
      return r;
   endfunction

   // byte a read returns, from the latch while one is held
   function automatic logic [7:0] rd_byte(input idt_cnt_t c);
      logic [15:0] v;
      v = c.held ? c.hold : c.count; // [R16]
      case (c.rl)
         IDT_RL_HI: rd_byte = v[15:8];
         IDT_RL_PAIR: rd_byte = c.rd_hi ? v[15:8] : v[7:0]; // [R15]
         default: rd_byte = v[7:0];
      endcase
   endfunction

   // counter index addressed by a data access, 3 when none
   function automatic logic [1:0] cnt_sel(input logic [7:0] a);
      case (a)
         IDT_ADR_CNT0: cnt_sel = 2'd0;
         IDT_ADR_CNT1: cnt_sel = 2'd1;
         IDT_ADR_CNT2: cnt_sel = 2'd2;
         default: cnt_sel = NO_CNT;
      endcase
   endfunction

   always_comb begin
      logic                req;
      logic                wr;
      logic                rd;
      logic [1:0]          ci;
      logic [1:0]          sc;
      logic [1:0]          rl;
      logic [7:0]          d;
      logic                done;
      logic [IDT_NIRQ-1:0] ev;
      // ack masks req so a strobe held into the ack cycle is not taken twice
      req  = wb_cyc_i & wb_stb_i & ~s_reg.ack;
      wr   = req & wb_we_i & wb_sel_i[0];
      rd   = req & ~wb_we_i;
      ci   = cnt_sel(wb_adr_i);
      d    = wb_dat_i[7:0];
      sc   = d[IDT_CW_SC +: 2];
      rl   = d[IDT_CW_RL +: 2];
      done = 1'b0;
      ev   = '0;
      s_next     = s_reg;
      s_next.ack = req;
      s_next.dat = '0;

      for (int i = 0; i < IDT_NCNT; i++) begin
         s_next.cnt[i] = step(s_reg.cnt[i], tick[i], gate_i[i], rise[RISE_GATE + i]);
      end

      // control byte: latch command or new configuration
      if (wr && wb_adr_i == IDT_ADR_CTRL && sc != IDT_SC_RDBK) begin
         if (rl == IDT_RL_LATCH) begin
            if (!s_reg.cnt[sc].held) begin
               s_next.cnt[sc].hold = s_reg.cnt[sc].count; // [R16]
               s_next.cnt[sc].held = 1'b1;                // [R16]
            end
         end else begin
            s_next.cnt[sc].mode  = mode_dec(d[IDT_CW_M +: 3]);
            s_next.cnt[sc].rl    = rl;
            s_next.cnt[sc].wr_hi = 1'b0; // [R15]
            s_next.cnt[sc].rd_hi = 1'b0; // [R15]
            s_next.cnt[sc].held  = 1'b0;
            s_next.cnt[sc].ldd   = 1'b0;
            s_next.cnt[sc].pend  = 1'b0;
            s_next.cnt[sc].trig  = 1'b0;
            s_next.cnt[sc].run   = 1'b0;
            s_next.cnt[sc].outv  = (mode_dec(d[IDT_CW_M +: 3]) != IDT_M_TCOUNT);
         end
      end

      // count byte writes; a half-written pair leaves the running count alone
      if (wr && ci != NO_CNT) begin
         case (s_reg.cnt[ci].rl)
            IDT_RL_LO: begin
               s_next.cnt[ci].reload = {IDT_BYTE0, d};
               done = 1'b1;
            end
            IDT_RL_HI: begin
               s_next.cnt[ci].reload = {d, IDT_BYTE0};
               done = 1'b1;
            end
            default: begin
               if (!s_reg.cnt[ci].wr_hi) begin
                  s_next.cnt[ci].lo_tmp = d;    // [R15]
                  s_next.cnt[ci].wr_hi  = 1'b1; // [R15]
               end else begin
                  s_next.cnt[ci].reload = {d, s_reg.cnt[ci].lo_tmp}; // [R15]
                  s_next.cnt[ci].wr_hi  = 1'b0;
                  done = 1'b1; // [R18]
               end
            end
         endcase
         if (done) begin
            s_next.cnt[ci].ldd  = 1'b1; // [R18]
            s_next.cnt[ci].pend = 1'b1; // [R18]
            if (s_reg.cnt[ci].mode == IDT_M_TCOUNT) begin
               s_next.cnt[ci].outv = 1'b0; // [R1]
               s_next.cnt[ci].run  = 1'b0;
            end
            if (s_reg.cnt[ci].mode == IDT_M_SWSTROBE) begin
               s_next.cnt[ci].outv = 1'b1; // [R7]
               s_next.cnt[ci].run  = 1'b0;
            end
         end
      end

      // reads and their sequencing side effects
      if (rd) begin
         case (wb_adr_i)
            IDT_ADR_BRD: begin
               s_next.dat[IDT_BRD_ARM]       = s_reg.arm;
               s_next.dat[IDT_BRD_CASC +: 2] = s_reg.casc;
            end
            IDT_ADR_ISTAT: s_next.dat[IDT_NIRQ-1:0] = s_reg.istat;
            IDT_ADR_IMASK: s_next.dat[IDT_NIRQ-1:0] = s_reg.imask;
            IDT_ADR_STAT: begin
               for (int i = 0; i < IDT_NCNT; i++) begin
                  s_next.dat[IDT_STAT_OUT + i]  = s_reg.cnt[i].outv;
                  s_next.dat[IDT_STAT_GATE + i] = gate_i[i]; // [R12]
               end
            end
            default: begin
               if (ci != NO_CNT) begin
                  s_next.dat[7:0] = rd_byte(s_reg.cnt[ci]); // [R11]
                  // the latch is freed only when its last byte is read
                  if (s_reg.cnt[ci].rl == IDT_RL_PAIR && !s_reg.cnt[ci].rd_hi) begin
                     s_next.cnt[ci].rd_hi = 1'b1; // [R15]
                  end else begin
                     s_next.cnt[ci].rd_hi = 1'b0;
                     s_next.cnt[ci].held  = 1'b0; // [R16]
                  end
               end
            end
         endcase
      end

      // board control and interrupt registers
      if (wr && wb_adr_i == IDT_ADR_BRD) begin
         s_next.arm   = d[IDT_BRD_ARM];
         s_next.casc  = d[IDT_BRD_CASC +: 2];
         s_next.istat[IDT_IRQ_TMR] = 1'b0; // [R14]
      end
      if (wr && wb_adr_i == IDT_ADR_ISTAT) begin
         s_next.istat = s_reg.istat & ~d[IDT_NIRQ-1:0];
      end
      if (wr && wb_adr_i == IDT_ADR_IMASK) begin
         s_next.imask = d[IDT_NIRQ-1:0];
      end

      // events set after clears so a simultaneous event is kept
      for (int i = 0; i < IDT_NCNT; i++) begin
         ev[IDT_IRQ_OUT + i] = ~s_reg.cnt[i].outv & s_next.cnt[i].outv;
      end
      ev[IDT_IRQ_TMR] = s_reg.arm & ev[IDT_IRQ_OUT + 2]; // [R14]
      s_next.istat = s_next.istat | ev;
      s_next.irq   = |(s_next.istat & s_next.imask);
   end

   // reset leaves every counter in configuration 0 with no count loaded
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wb_ack_o = s_reg.ack;
   assign wb_dat_o = s_reg.dat;
   assign irq_o    = s_reg.irq;
   always_comb begin
      for (int i = 0; i < IDT_NCNT; i++) begin
         cnt_out_o[i] = s_reg.cnt[i].outv;
      end
   end
endmodule
`default_nettype wire

// >>> tb/idt_ext_src.sv
// far-side model: external counter clocks and gate levels
`timescale 1ns/10ps
`default_nettype none
module idt_ext_src (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // commands from the bench
   input  wire logic [1:0] pulse_i,
   input  wire logic [2:0] gate_i,
   // pins toward the timer
   output logic      [1:0] clk_o,
   output logic      [2:0] gate_o
);
   logic [2:0] ph_reg [2];
   // clocks stand low between requested pulses, two cycles high each
   always_ff @(posedge clk_i) begin
      gate_o <= rst_i ? 3'h0 : gate_i;
      for (int i = 0; i < 2; i++) begin
         ph_reg[i] <= rst_i ? 3'h0 : (ph_reg[i] != 3'h0) ? ph_reg[i] - 3'h1 : {pulse_i[i], 2'h0};
      end
   end
   assign clk_o[0] = ph_reg[0] >= 3'h3;
   assign clk_o[1] = ph_reg[1] >= 3'h3;
endmodule
`default_nettype wire

// >>> tb/idt_timer_monitor.sv
// port checker of the interval delay timer and its bind
`timescale 1ns/10ps
`default_nettype none
module idt_timer_monitor
   import idt_pkg::*;
(
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // pins
   input wire logic [1:0]  cnt_clk_i,
   input wire logic [2:0]  cnt_out_o,
   input wire logic        irq_o
);
   logic       take;
   logic [1:0] cause;
   logic [5:0] h0_reg;
   logic [5:0] h1_reg;
   logic       o2_reg;
   logic       st_rd;
   logic       mask0;
   assign take  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign st_rd = take & ~wb_we_i & (wb_adr_i == IDT_ADR_STAT);
   assign mask0 = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == IDT_ADR_IMASK)
                  & (wb_dat_i[3:0] == 4'h0);
   // cascading lets a counter 2 edge move the other outputs too
   assign cause = {2{wb_cyc_i | (cnt_out_o[2] ^ o2_reg)}} | cnt_clk_i;
   always_ff @(posedge clk_i) begin
      o2_reg <= cnt_out_o[2];
      h0_reg <= {h0_reg[4:0], cause[0]};
      h1_reg <= {h1_reg[4:0], cause[1]};
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_next: assert property (take |=> wb_ack_o)
      else $error("request not answered next cycle");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property (wb_ack_o |-> $past(take))
      else $error("ack without request");
   chk_write_zero: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
      else $error("write answered with data");
   chk_stat_out: assert property (wb_ack_o && $past(st_rd)
      |-> wb_dat_o[2:0] == $past(cnt_out_o))
      else $error("status outputs differ from pins");
   chk_irq_mask: assert property (wb_ack_o && $past(mask0) |=> !irq_o)
      else $error("interrupt while all masked");
   chk_out0_cause: assert property ($changed(cnt_out_o[0]) |-> h0_reg != 6'h00)
      else $error("counter 0 output moved without cause");
   chk_out1_cause: assert property ($changed(cnt_out_o[1]) |-> h1_reg != 6'h00)
      else $error("counter 1 output moved without cause");
   cov_strobe: cover property ($fell(cnt_out_o[2]));
   cov_irq: cover property ($rose(irq_o));
   cov_out1: cover property ($rose(cnt_out_o[1]));
endmodule
bind idt_timer idt_timer_monitor u_mon (
   .clk_i    (clk_i),
   .rst_i    (rst_i),
   .wb_cyc_i (wb_cyc_i),
   .wb_stb_i (wb_stb_i),
   .wb_we_i  (wb_we_i),
   .wb_adr_i (wb_adr_i),
   .wb_sel_i (wb_sel_i),
   .wb_dat_i (wb_dat_i),
   .wb_dat_o (wb_dat_o),
   .wb_ack_o (wb_ack_o),
   .cnt_clk_i(cnt_clk_i),
   .cnt_out_o(cnt_out_o),
   .irq_o    (irq_o)
);
`default_nettype wire

// >>> tb/idt_timer_test.sv
// self-checking bench of the interval delay timer
`timescale 1ns/10ps
`default_nettype none
module idt_timer_test
   import idt_pkg::*;
();
   localparam int TD = 4;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        irq_o;
   logic [1:0]  cnt_clk;
   logic [1:0]  pulse = 2'h0;
   logic [2:0]  gate;
   logic [2:0]  gate_cmd = 3'h0;
   logic [2:0]  cnt_out;
   logic [31:0] exp_q[$];
   string       nm_q[$];
   int          n_fail = 0;
   int          n_tests = 0;
   int          n;
   int          seed = 37;
   logic [31:0] rnd;
   always #5 clk_i = ~clk_i;
   idt_timer #(.TICK_DIV(TD)) u_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cnt_clk_i(cnt_clk), .gate_i(gate),
      .cnt_out_o(cnt_out), .irq_o(irq_o));
   idt_ext_src u_src (.clk_i(clk_i), .rst_i(rst_i), .pulse_i(pulse), .gate_i(gate_cmd),
      .clk_o(cnt_clk), .gate_o(gate));
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wt(input int c);
      repeat (c) @(posedge clk_i);
   endtask
   // one classic cycle; the bench watchdog bounds the wait for ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h0, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      nm_q.push_back(nm);
      wb(1'b0, a, 8'h00);
   endtask
   task automatic ld(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
      wb(1'b1, a, lo);
      wb(1'b1, a, hi);
   endtask
   task automatic pls(input int i);
      @(posedge clk_i);
      pulse[i] <= 1'b1;
      @(posedge clk_i);
      pulse[i] <= 1'b0;
      wt(6);
   endtask
   task automatic lvl(input int i, input logic v);
      n = 0;
      while (cnt_out[i] !== v) begin
         @(posedge clk_i);
         n++;
      end
   endtask
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) cmp(nm_q.pop_front(), exp_q.pop_front(), wb_dat_o);
   end
   initial begin
      wt(6000);
      n_fail++;
      test_done();
   end
   initial begin
      wt(8);
      rst_i <= 1'b0;
      rnd = $random(seed);
      wb(1'b1, IDT_ADR_IMASK, rnd[7:0]);
      rd("imask", IDT_ADR_IMASK, {28'h0, rnd[3:0]});
      wb(1'b1, IDT_ADR_IMASK, 8'h00);
      rd("board", IDT_ADR_BRD, 32'h0);
      rd("unmapped", 8'h20, 32'h0);
      $display("test registers done");
      gate_cmd[0] <= 1'b1;
      wb(1'b1, IDT_ADR_CTRL, 8'h30);
      ld(IDT_ADR_CNT0, 8'h03, 8'h00);
      cmp("out0 load", 1'b0, cnt_out[0]);
      pls(0);
      pls(0);
      gate_cmd[0] <= 1'b0;
      wt(3);
      repeat (3) pls(0);
      wb(1'b1, IDT_ADR_CTRL, 8'h00);
      rd("cnt0 lo", IDT_ADR_CNT0, 32'h02);
      rd("cnt0 hi", IDT_ADR_CNT0, 32'h00);
      cmp("out0 held", 1'b0, cnt_out[0]);
      gate_cmd[0] <= 1'b1;
      pls(0);
      pls(0);
      cmp("out0 zero", 1'b1, cnt_out[0]);
      ld(IDT_ADR_CNT0, 8'h03, 8'h00);
      cmp("out0 reload", 1'b0, cnt_out[0]);
      $display("test config0 done");
      wb(1'b1, IDT_ADR_CTRL, 8'h72);
      ld(IDT_ADR_CNT1, 8'h03, 8'h00);
      cmp("out1 idle", 1'b1, cnt_out[1]);
      gate_cmd[1] <= 1'b1;
      pls(1);
      cmp("out1 trig", 1'b0, cnt_out[1]);
      gate_cmd[1] <= 1'b0;
      pls(1);
      pls(1);
      gate_cmd[1] <= 1'b1;
      repeat (3) pls(1);
      cmp("out1 retrig", 1'b0, cnt_out[1]);
      pls(1);
      cmp("out1 done", 1'b1, cnt_out[1]);
      $display("test config1 done");
      rd("status", IDT_ADR_STAT, 32'h32);
      wb(1'b1, IDT_ADR_CTRL, 8'h60);
      wb(1'b1, IDT_ADR_CNT1, 8'h05);
      pls(1);
      rd("cnt1 hi only", IDT_ADR_CNT1, 32'h05);
      gate_cmd[2] <= 1'b1;
      wb(1'b1, IDT_ADR_CTRL, 8'hB8);
      wb(1'b1, IDT_ADR_CNT2, 8'h04);
      wt(40);
      cmp("out2 half load", 1'b1, cnt_out[2]);
      wb(1'b1, IDT_ADR_CNT2, 8'h00);
      lvl(2, 1'b0);
      cmp("sw delay", 1'b1, n >= 4 * TD && n <= 6 * TD + 2);
      lvl(2, 1'b1);
      cmp("sw strobe", TD, n);
      $display("test config4 done");
      gate_cmd[2] <= 1'b0;
      wb(1'b1, IDT_ADR_CTRL, 8'hBA);
      ld(IDT_ADR_CNT2, 8'h06, 8'h00);
      wt(40);
      cmp("out2 idle", 1'b1, cnt_out[2]);
      gate_cmd[2] <= 1'b1;
      wt(12);
      gate_cmd[2] <= 1'b0;
      wt(2);
      gate_cmd[2] <= 1'b1;
      lvl(2, 1'b0);
      cmp("hw retrig", 1'b1, n >= 6 * TD - 2 && n <= 8 * TD + 2);
      lvl(2, 1'b1);
      cmp("hw strobe", TD, n);
      $display("test config5 done");
      gate_cmd[2] <= 1'b0;
      wb(1'b1, IDT_ADR_CTRL, 8'hB0);
      ld(IDT_ADR_CNT2, 8'hFF, 8'hFF);
      wt(12);
      gate_cmd[2] <= 1'b1;
      wt(10 * TD);
      gate_cmd[2] <= 1'b0;
      wt(8);
      wb(1'b1, IDT_ADR_CTRL, 8'h80);
      rd("width lo", IDT_ADR_CNT2, 32'hF5);
      rd("width hi", IDT_ADR_CNT2, 32'hFF);
      $display("test width done");
      wb(1'b1, IDT_ADR_IMASK, 8'h01);
      wb(1'b1, IDT_ADR_BRD, 8'h03);
      wb(1'b1, IDT_ADR_CTRL, 8'h30);
      ld(IDT_ADR_CNT0, 8'h02, 8'h00);
      gate_cmd[2] <= 1'b1;
      wb(1'b1, IDT_ADR_CTRL, 8'hB6);
      ld(IDT_ADR_CNT2, 8'h04, 8'h00);
      while (irq_o !== 1'b1) @(posedge clk_i);
      // clear just after a fresh fall, well before the next rise sets it again
      lvl(2, 1'b1);
      lvl(2, 1'b0);
      wb(1'b1, IDT_ADR_ISTAT, 8'h01);
      wt(1);
      cmp("irq cleared", 1'b0, irq_o);
      while (irq_o !== 1'b1) @(posedge clk_i);
      wb(1'b1, IDT_ADR_BRD, 8'h03);
      wt(1);
      cmp("irq by board", 1'b0, irq_o);
      wt(80);
      cmp("cascade out0", 1'b1, cnt_out[0]);
      wb(1'b1, IDT_ADR_IMASK, 8'h00);
      wt(40);
      cmp("irq masked", 1'b0, irq_o);
      $display("test interrupt done");
      test_done();
   end
endmodule
`default_nettype wire
